// ---- design/bts_exec.sv ----
// Purpose: Decode and execute bit-test-and-skip and bit-set on the banked data memory
// Assumes: One clk is one phase; four phases per instruction cycle; sync RAM with one-cycle read
// Notes:   Other opcodes are ignored here and left to the rest of the core
//
// Contract
// - Opcode 1011 skips when tested bit clear
// - Opcode 1010 skips when tested bit set
// - Skip discards the prefetched instruction
// - Discarded instruction becomes one no-op cycle
// - Skipped two-word instruction gives two no-ops
// - Access bit zero selects fixed access bank
// - Access bit one uses bank select register
// - Extended set, access zero, f<=95: indexed

`timescale 1ns/1ps

module bts_exec (
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic [15:0]                instrWord,      // Fetched program word, held over Q1
    input  wire logic                       instrValid,     // Word in instrWord is real
    input  wire logic                       nextTwoWord,    // Prefetched next instruction is two words
    input  wire logic                       extEnable,      // Extended instruction set enabled
    input  wire logic [bts_pkg::BANK_W-1:0] bankSelect,     // bank_select_register contents
    input  wire logic [bts_pkg::ADDR_W-1:0] indexBase,      // Base pointer for indexed literal offset
    input  wire logic [7:0]                 memRdData,      // Read data, valid in Q3
    output logic [bts_pkg::ADDR_W-1:0]      memAddr_q,      // Data memory address
    output logic                            memRdEn_q,      // Read strobe in Q2
    output logic                            memWrEn_q,      // Write strobe in Q4
    output logic [7:0]                      memWrData_q,    // Write data in Q4
    output logic                            squash_q,       // Discard prefetched instruction
    output logic                            nopSlot_q,      // Current cycle is a no_operation_slot
    output logic                            statusWe_q      // Status flag write, always low here
);

    // Phase and operation state
    bts_pkg::bts_phase_e phase_q;                           // Current phase
    bts_pkg::bts_phase_e phase_d;
    bts_pkg::bts_op_e    op_q;                              // Operation of this cycle
    bts_pkg::bts_op_e    op_d;
    logic [2:0]          bitIdx_q;                          // Latched bit index
    logic [1:0]          skipCnt_q;                         // No-op cycles still owed
    logic                twoWord_q;                         // Skip covers a two-word instruction

    // Decode wires
    bts_pkg::bts_instr_s instr;                             // Fields of fetched word
    wire logic           isQ1 = (phase_q == bts_pkg::PH_Q1);
    wire logic           isQ2 = (phase_q == bts_pkg::PH_Q2);
    wire logic           isQ3 = (phase_q == bts_pkg::PH_Q3);
    wire logic           isQ4 = (phase_q == bts_pkg::PH_Q4);
    // A no-op slot swallows whatever word shows up, so decode is blocked there
    wire logic           takeWord = isQ1 && instrValid && !nopSlot_q;
    wire logic           opIsClr  = takeWord && (instr.opcode == bts_pkg::OPC_SKIP_CLR);
    wire logic           opIsSet  = takeWord && (instr.opcode == bts_pkg::OPC_SKIP_SET);
    wire logic           opIsBsf  = takeWord && (instr.opcode == bts_pkg::OPC_BIT_SET);

    assign instr = bts_pkg::bts_instr_s'(instrWord);

    // Operand address selection
    wire logic                       useIndexed  = extEnable && !instr.access &&
                                                   (instr.fileAddr <= bts_pkg::IDX_LIMIT);
    wire logic [bts_pkg::ADDR_W-1:0] idxAddr     = bts_pkg::ADDR_W'(indexBase + {4'h0, instr.fileAddr});
    wire logic [3:0]                 accBank     = (instr.fileAddr < bts_pkg::ACCESS_SPLIT) ?
                                                   bts_pkg::ACC_LOW_BANK : bts_pkg::ACC_HIGH_BANK;
    wire logic [bts_pkg::ADDR_W-1:0] accAddr     = {accBank, instr.fileAddr};
    wire logic [bts_pkg::ADDR_W-1:0] bankAddr    = {bankSelect, instr.fileAddr};
    wire logic [bts_pkg::ADDR_W-1:0] operandAddr = instr.access ? bankAddr :
                                                   (useIndexed ? idxAddr : accAddr);

    // Bit evaluation in Q3
    wire logic       testBit   = memRdData[bitIdx_q];
    wire logic       skipNow   = isQ3 && (((op_q == bts_pkg::OP_CLR) && !testBit) ||
                                          ((op_q == bts_pkg::OP_SET) &&  testBit));
    wire logic [7:0] setMask   = 8'h01 << bitIdx_q;
    wire logic [1:0] skipLen   = nextTwoWord ? bts_pkg::SKIP_TWO_WORD : bts_pkg::SKIP_ONE_WORD;

    // Phase rotation, free running
    always_comb begin
        case (phase_q)
            bts_pkg::PH_Q1: phase_d = bts_pkg::PH_Q2;
            bts_pkg::PH_Q2: phase_d = bts_pkg::PH_Q3;
            bts_pkg::PH_Q3: phase_d = bts_pkg::PH_Q4;
            bts_pkg::PH_Q4: phase_d = bts_pkg::PH_Q1;
            default:        phase_d = bts_pkg::PH_Q1;
        endcase
    end

    // Operation held from Q1 decode until the end of Q4
    always_comb begin
        op_d = op_q;
        if (isQ1) begin
            if (opIsClr) begin
                op_d = bts_pkg::OP_CLR;
            end else if (opIsSet) begin
                op_d = bts_pkg::OP_SET;
            end else if (opIsBsf) begin
                op_d = bts_pkg::OP_BSF;
            end else begin
                op_d = bts_pkg::OP_IDLE;
            end
        end else if (isQ4) begin
            op_d = bts_pkg::OP_IDLE;
        end
    end

    // Phase and operation registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= bts_pkg::PH_Q1;
            op_q    <= bts_pkg::OP_IDLE;
        end else begin
            phase_q <= phase_d;
            op_q    <= op_d;
        end
    end

    // Memory read in Q2, address fixed from Q1 decode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            memAddr_q <= bts_pkg::ADDR_RST;
            memRdEn_q <= 1'b0;
            bitIdx_q  <= 3'h0;
        end else begin
            memRdEn_q <= opIsClr || opIsSet || opIsBsf;
            if (takeWord) begin
                memAddr_q <= operandAddr;
                bitIdx_q  <= instr.bitIdx;
            end
        end
    end

    // Read-modify-write tail of bit set, written in Q4
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            memWrEn_q   <= 1'b0;
            memWrData_q <= bts_pkg::DATA_RST;
        end else begin
            memWrEn_q <= isQ3 && (op_q == bts_pkg::OP_BSF);
            if (isQ3) begin
                memWrData_q <= memRdData | setMask;
            end
        end
    end

    // Skip bookkeeping; squash shows in Q4, no-op slots start at the next Q1
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            squash_q  <= 1'b0;
            twoWord_q <= 1'b0;
            skipCnt_q <= bts_pkg::SKIP_CNT_RST;
            nopSlot_q <= 1'b0;
        end else begin
            squash_q <= skipNow;
            if (skipNow) begin
                skipCnt_q <= skipLen;
                twoWord_q <= nextTwoWord;
            end else if (isQ4) begin
                if (skipCnt_q != bts_pkg::SKIP_CNT_RST) begin
                    nopSlot_q <= 1'b1;
                    skipCnt_q <= skipCnt_q - 2'h1;
                end else begin
                    nopSlot_q <= 1'b0;
                end
            end
        end
    end

    // None of these operations touches the arithmetic flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            statusWe_q <= 1'b0;
        end else begin
            statusWe_q <= 1'b0;
        end
    end

    // Checks
    chk_clr_skip: assert property (@(posedge clk) disable iff (!arst_n)
        isQ3 && (op_q == bts_pkg::OP_CLR) && !testBit |=> squash_q && isQ4)
        else $error("skip on clear did not squash");

    chk_set_skip: assert property (@(posedge clk) disable iff (!arst_n)
        isQ3 && (op_q == bts_pkg::OP_SET) && testBit |=> squash_q)
        else $error("skip on set did not squash");

    chk_squash_blocks: assert property (@(posedge clk) disable iff (!arst_n)
        squash_q |=> nopSlot_q && !memRdEn_q ##1 !memRdEn_q ##1 (op_q == bts_pkg::OP_IDLE))
        else $error("squashed instruction still executed");

    chk_one_nop: assert property (@(posedge clk) disable iff (!arst_n)
        squash_q && !twoWord_q |=> nopSlot_q [*4] ##1 !nopSlot_q)
        else $error("single skip not one no-op cycle");

    chk_two_nop: assert property (@(posedge clk) disable iff (!arst_n)
        squash_q && twoWord_q |=> nopSlot_q [*8] ##1 !nopSlot_q)
        else $error("two-word skip not two no-op cycles");

    // Expected bank worked out from the split constant, so a swapped half would fire
    chk_access_bank: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(memRdEn_q) && !$past(instr.access) &&
        !($past(extEnable) && ($past(instr.fileAddr) <= bts_pkg::IDX_LIMIT)) |->
        (memAddr_q[7:0] == $past(instr.fileAddr)) &&
        (memAddr_q[11:8] == (($past(instr.fileAddr) < bts_pkg::ACCESS_SPLIT) ?
                             bts_pkg::ACC_LOW_BANK : bts_pkg::ACC_HIGH_BANK)))
        else $error("access bank address wrong");

    chk_bank_select: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(memRdEn_q) && $past(instr.access) |-> memAddr_q == {$past(bankSelect), $past(instr.fileAddr)})
        else $error("banked address not from bank select");

    // Condition and sum written out here, not taken from the decode wires
    chk_indexed_addr: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(memRdEn_q) && $past(extEnable) && !$past(instr.access) &&
        ($past(instr.fileAddr) <= bts_pkg::IDX_LIMIT) |->
        memAddr_q == bts_pkg::ADDR_W'($past(indexBase) + {4'h0, $past(instr.fileAddr)}))
        else $error("indexed literal offset address wrong");

    chk_phase_order: assert property (@(posedge clk) disable iff (!arst_n)
        memWrEn_q |-> isQ4 && $past(memRdEn_q, 2) && $past(isQ2, 2))
        else $error("bit set write not in Q4 after Q2 read");

    chk_read_phase: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(memRdEn_q) |-> isQ2 ##1 (isQ3 && !memRdEn_q))
        else $error("read strobe outside Q2");

    chk_flags_kept: assert property (@(posedge clk) disable iff (!arst_n)
        (op_q != bts_pkg::OP_IDLE) |-> !statusWe_q)
        else $error("status written by bit operation");

endmodule

// ---- shared/bts_pkg.sv ----
// Purpose: Shared constants and types for the bit-test/skip and bit-set execution block
// Assumes: 16-bit program words, 8-bit data, 12-bit data addresses
// Notes:   Bank select width and access split are plain defaults, not tied to any part

package bts_pkg;

    // Instruction field layout
    localparam int OPC_MSB     = 15;
    localparam int OPC_LSB     = 12;
    localparam int BIT_MSB     = 11;
    localparam int BIT_LSB     = 9;
    localparam int ACCESS_POS  = 8;
    localparam int FILE_MSB    = 7;
    localparam int FILE_LSB    = 0;

    // Opcode patterns
    localparam logic [3:0] OPC_SKIP_CLR = 4'hB;          // skip_on_bit_clear_op
    localparam logic [3:0] OPC_SKIP_SET = 4'hA;          // skip_on_bit_set_op
    localparam logic [3:0] OPC_BIT_SET  = 4'h8;          // single_bit_set_op

    // Addressing
    localparam int         ADDR_W        = 12;
    localparam int         BANK_W        = 4;
    localparam logic [7:0] IDX_LIMIT     = 8'h5F;        // Highest indexed literal offset
    localparam logic [7:0] ACCESS_SPLIT  = 8'h60;        // Access bank low/high boundary
    localparam logic [3:0] ACC_LOW_BANK  = 4'h0;         // Bank of low access half
    localparam logic [3:0] ACC_HIGH_BANK = 4'hF;         // Bank of high access half

    // Skip lengths in no_operation_slot cycles
    localparam logic [1:0] SKIP_ONE_WORD = 2'h1;
    localparam logic [1:0] SKIP_TWO_WORD = 2'h2;

    // Reset values
    localparam logic [1:0]        SKIP_CNT_RST = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST     = 12'h000;
    localparam logic [7:0]        DATA_RST     = 8'h00;

    // Four clock phases per instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } bts_phase_e;

    // Operation being executed in this instruction cycle
    typedef enum logic [3:0] {
        OP_IDLE = 4'b0001,
        OP_CLR  = 4'b0010,
        OP_SET  = 4'b0100,
        OP_BSF  = 4'b1000
    } bts_op_e;

    // Program word split into fields
    typedef struct packed {
        logic [3:0] opcode;
        logic [2:0] bitIdx;
        logic       access;
        logic [7:0] fileAddr;
    } bts_instr_s;

endpackage

// ---- tb/bts_exec_bench.sv ----
// Purpose: Self-checking bench for the bit-test/skip and bit-set execution block
// Assumes: One clk per phase; the reset release edge starts Q1
// Notes:   Integer reference model; stimulus from a fixed xorshift seed

`timescale 1ns/1ps

module bts_exec_bench;
    logic                       clk;          // 250 MHz phase clock
    logic                       arst_n;       // Async reset, active low
    logic [15:0]                instrWord;    // Word offered in Q1
    logic                       instrValid;   // Word is real
    logic                       nextTwoWord;  // Prefetched word is two words
    logic                       extEnable;    // Extended set on
    logic [bts_pkg::BANK_W-1:0] bankSelect;   // Bank select value
    logic [bts_pkg::ADDR_W-1:0] indexBase;    // Indexed base pointer
    logic [7:0]                 memRdData;    // Operand from memory
    logic [bts_pkg::ADDR_W-1:0] memAddr_q;    // Operand address seen
    logic                       memRdEn_q;    // Read strobe seen
    logic                       memWrEn_q;    // Write strobe seen
    logic [7:0]                 memWrData_q;  // Write data seen
    logic                       squash_q;     // Discard strobe seen
    logic                       nopSlot_q;    // No-op cycle flag seen
    logic                       statusWe_q;   // Status write seen
    int                         error_cnt;    // Mismatches
    int                         total_checks; // Comparisons
    int                         cycles;       // Hang guard
    logic [31:0]                rngState;     // Xorshift state
    logic [3:0]                 opTable [5];  // Opcode mix, two ignored ones

    bts_exec dut (.clk(clk), .arst_n(arst_n), .instrWord(instrWord), .instrValid(instrValid),
        .nextTwoWord(nextTwoWord), .extEnable(extEnable), .bankSelect(bankSelect),
        .indexBase(indexBase), .memRdData(memRdData), .memAddr_q(memAddr_q), .memRdEn_q(memRdEn_q),
        .memWrEn_q(memWrEn_q), .memWrData_q(memWrData_q), .squash_q(squash_q),
        .nopSlot_q(nopSlot_q), .statusWe_q(statusWe_q));

    // Free-running phase clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Hang guard: far above the few thousand clocks the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("BAD timeout expected end of run seen %0d clocks", cycles);
            final_report();
        end
    end

    // Xorshift source, fixed seed so runs repeat
    function logic [31:0] next_rand();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction

    // Single comparison point, four-state exact
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run, the one exit
    task final_report();
        $display("Counts: %0d checks, %0d mismatches", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One instruction cycle; entered in the time step of the edge that starts Q1
    task automatic run_op(input logic [15:0] word, input logic valid, input logic [7:0] data,
                          input logic two);
        logic [31:0] r;
        int          op, b, f, addr, nops;
        logic        dec, skip;
        r = next_rand();
        op = word[15:12];
        b = word[11:9];
        f = word[7:0];
        dec = valid && (op == 11 || op == 10 || op == 8);
        skip = dec && ((op == 11 && !data[b]) || (op == 10 && data[b]));
        nops = skip ? (two ? 8 : 4) : 0;
        // Expected operand address from the three addressing cases
        if (word[8]) addr = r[3:0] * 256 + f;
        else if (r[4] && f <= bts_pkg::IDX_LIMIT) addr = (r[27:16] + f) % 4096;
        else addr = (f < bts_pkg::ACCESS_SPLIT) ? f : bts_pkg::ACC_HIGH_BANK * 256 + f;
        instrWord <= word;
        instrValid <= valid;
        bankSelect <= r[3:0];
        extEnable <= r[4];
        indexBase <= r[27:16];
        @(posedge clk);
        // Junk on the word bus after Q1 must not matter
        instrWord <= 16'(next_rand());
        memRdData <= data;
        nextTwoWord <= two;
        #1;
        check("memRdEn Q2", memRdEn_q, dec);
        if (dec) check("memAddr", memAddr_q, 16'(addr));
        check("nopSlot Q2", nopSlot_q, 0);
        repeat (2) @(posedge clk);
        #1;
        check("squash Q4", squash_q, skip);
        check("memWrEn Q4", memWrEn_q, dec && op == 8);
        if (dec && op == 8) check("memWrData", memWrData_q, data | (8'h01 << b));
        check("memRdEn Q4", memRdEn_q, 0);
        check("statusWe", statusWe_q, 0);
        @(posedge clk);
        // Skipped word offered with valid high must be swallowed
        repeat (nops) begin
            instrWord <= 16'(next_rand());
            instrValid <= 1'b1;
            #1;
            check("nopSlot", nopSlot_q, 1);
            check("memRdEn nop", memRdEn_q, 0);
            @(posedge clk);
        end
    endtask

    // Main sequence
    initial begin
        logic [31:0] w;
        opTable = '{4'hB, 4'hA, 4'h8, 4'h7, 4'h0};
        rngState = 32'h6408_2d66;
        {arst_n, instrValid, nextTwoWord, extEnable} = 4'h0;
        {instrWord, bankSelect, indexBase, memRdData} = 40'h00_0000_0000;
        repeat (12) @(posedge clk);
        #1;
        check("outs in reset", {memRdEn_q, memWrEn_q, squash_q, nopSlot_q, statusWe_q}, 0);
        check("memAddr in reset", memAddr_q, 0);
        $display("Test reset finished");
        @(posedge clk);
        arst_n <= 1'b1;
        run_op(16'h8F25, 1'b1, 8'h0A, 1'b0);
        run_op(16'hB000, 1'b1, 8'hFE, 1'b0);
        run_op(16'hB000, 1'b1, 8'h01, 1'b1);
        run_op(16'hBE40, 1'b1, 8'h7F, 1'b1);
        run_op(16'hA610, 1'b1, 8'h08, 1'b1);
        run_op(16'hA610, 1'b1, 8'hF7, 1'b0);
        run_op(16'hA000, 1'b0, 8'h01, 1'b0);
        $display("Test directed finished");
        repeat (400) begin
            w = next_rand();
            run_op({opTable[w[31:20] % 5], w[11:0]}, w[13] | w[14], w[27:20], w[15]);
        end
        $display("Test random finished");
        final_report();
    end
endmodule
